// ===== rtl/pa_protect_pkg.sv
// constants for the protection and transmit-gate register slice
package pa_protect_pkg;
    localparam int NUM_PATHS = 2;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int SAMPLE_W = 16;
    localparam int MSB_KEEP = 6;
    localparam int POWER_W = 13;
    localparam int SQ_W = 12;
    localparam int ACC_W = 16;
    localparam int CNT_W = 3;
    localparam int LEN_W = 2;
    localparam int IRQ_W = 9;

    localparam logic [11:0] ADDR_LIMIT_LOW = 12'h588;
    localparam logic [11:0] ADDR_LIMIT_HIGH = 12'h589;
    localparam logic [11:0] ADDR_SHORT_CONTROL = 12'h58A;
    localparam logic [11:0] ADDR_POWER_LOW = 12'h58B;
    localparam logic [11:0] ADDR_POWER_HIGH = 12'h58C;
    localparam logic [11:0] ADDR_FSM_CONTROL = 12'h58D;
    localparam logic [11:0] ADDR_BLANKING = 12'h596;
    localparam logic [11:0] ADDR_IRQ_LOW = 12'h597;
    localparam logic [11:0] ADDR_IRQ_HIGH = 12'h598;
    localparam logic [11:0] ADDR_FLUSH = 12'h599;

    localparam int BIT_FSM_ENABLE = 0;
    localparam int BIT_SW_OVERRIDE = 2;
    localparam int BIT_SW_VALUE = 3;
    localparam int BIT_SHORT_ENABLE = 7;
    localparam int BIT_FLUSH_ENABLE = 0;
    localparam int BIT_IRQ_HIGH = 8;

    localparam logic FSM_ENABLE_RESET = 1'h0;
    localparam logic SW_OVERRIDE_RESET = 1'h0;
    localparam logic SW_VALUE_RESET = 1'h0;
    localparam logic FLUSH_ENABLE_RESET = 1'h1;
    localparam logic SHORT_ENABLE_RESET = 1'h0;
    localparam logic [1:0] LENGTH_RESET = 2'h0;
    localparam logic [12:0] LIMIT_RESET = 13'h0000;
    localparam logic [8:0] IRQ_RESET = 9'h000;
    localparam logic [7:0] READ_ZERO = 8'h00;
endpackage : pa_protect_pkg

// ===== rtl/short_window_power.sv
// short-window power averaging and limit compare for one datapath
`timescale 1ns/1ps
module short_window_power (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic pa_tick,
    input wire logic [pa_protect_pkg::SAMPLE_W-1:0] sample_i,
    input wire logic [pa_protect_pkg::SAMPLE_W-1:0] sample_q,
    input wire logic short_window_enable,
    input wire logic [pa_protect_pkg::LEN_W-1:0] short_window_length,
    input wire logic [pa_protect_pkg::POWER_W-1:0] short_window_limit,
    output logic [pa_protect_pkg::POWER_W-1:0] short_window_power_r,
    output logic limit_error_r
);
    logic signed [pa_protect_pkg::MSB_KEEP-1:0] top_i;
    logic signed [pa_protect_pkg::MSB_KEEP-1:0] top_q;
    logic [pa_protect_pkg::SQ_W-1:0] sample_power;
    logic [pa_protect_pkg::ACC_W-1:0] acc_r;
    logic [pa_protect_pkg::ACC_W-1:0] acc_nxt;
    logic [pa_protect_pkg::ACC_W-1:0] acc_sum;
    logic [pa_protect_pkg::CNT_W-1:0] cnt_r;
    logic [pa_protect_pkg::CNT_W-1:0] cnt_nxt;
    logic [pa_protect_pkg::CNT_W-1:0] cnt_last;
    logic [pa_protect_pkg::POWER_W-1:0] short_window_power_nxt;
    logic limit_error_nxt;
    logic signed [11:0] sq_i;
    logic signed [11:0] sq_q;

    // six most significant bits only
    assign top_i = sample_i[pa_protect_pkg::SAMPLE_W-1 -: pa_protect_pkg::MSB_KEEP]; // R01
    assign top_q = sample_q[pa_protect_pkg::SAMPLE_W-1 -: pa_protect_pkg::MSB_KEEP]; // R01
    assign sq_i = top_i * top_i;
    assign sq_q = top_q * top_q;
    assign sample_power = 12'(sq_i) + 12'(sq_q); // R01
    assign acc_sum = acc_r + {{(pa_protect_pkg::ACC_W-pa_protect_pkg::SQ_W){1'b0}}, sample_power};
    assign cnt_last = 3'((4'h1 << short_window_length) - 4'h1); // R10

    always_comb begin
        acc_nxt = acc_r;
        cnt_nxt = cnt_r;
        short_window_power_nxt = short_window_power_r;
        limit_error_nxt = limit_error_r;
        if (!short_window_enable) begin // R12
            acc_nxt = '0;
            cnt_nxt = '0;
            limit_error_nxt = 1'b0;
        end else if (pa_tick) begin
            if (cnt_r >= cnt_last) begin // R10
                // whole result replaced at once
                short_window_power_nxt = 13'(acc_sum >> short_window_length); // R14
                limit_error_nxt = 13'(acc_sum >> short_window_length) > short_window_limit; // R13
                acc_nxt = '0;
                cnt_nxt = '0;
            end else begin
                acc_nxt = acc_sum;
                cnt_nxt = 3'(cnt_r + 3'h1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            acc_r <= '0;
            cnt_r <= '0;
            short_window_power_r <= '0;
            limit_error_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            cnt_r <= cnt_nxt;
            short_window_power_r <= short_window_power_nxt;
            limit_error_r <= limit_error_nxt;
        end
    end
endmodule : short_window_power

// ===== rtl/pa_protect_txen_regs.sv
// paged register bank for power protection and transmit gating
// Contract
// R01: power is I squared plus Q squared from six top bits of each sample.
// R02: 13-bit read-only result; low byte, then bits 12:8 in next byte low five bits.
// R03: per-datapath registers act on the copy chosen by the page select field.
// R04: transmit-gate state machine runs only while its enable bit 0 is set; resets 0.
// R05: blanking bit 2 hands transmit-gate status to software; resets to pin control.
// R06: under software override, gate status equals blanking bit 3.
// R07: nine enable bits gate link-event interrupts, bit 8 down to bit 0.
// R08: enable bits 7:0 in first register, bit 8 in bit 0 of second.
// R09: datapath flush runs while flush enable set; it resets to one.
// R10: average spans two to the power of the two-bit length field, in PA periods.
// R11: PA period is 4 or 8 times main interpolation, else 32 DAC clocks.
// R12: power calculation and error detection active only while enable bit 7 set.
// R13: average compared with 13-bit split limit; error flagged when exceeded.
// R14: both readback bytes update together from one averaging window.
`timescale 1ns/1ps
module pa_protect_txen_regs (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [pa_protect_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_write,
    input wire logic [pa_protect_pkg::DATA_W-1:0] reg_wdata,
    output logic [pa_protect_pkg::DATA_W-1:0] reg_rdata_r,
    input wire logic [pa_protect_pkg::NUM_PATHS-1:0] main_datapath_page_select,
    input wire logic [pa_protect_pkg::NUM_PATHS-1:0] tx_gate_input,
    input wire logic [pa_protect_pkg::NUM_PATHS-1:0] pa_tick,
    input wire logic [pa_protect_pkg::NUM_PATHS*pa_protect_pkg::SAMPLE_W-1:0] sample_i,
    input wire logic [pa_protect_pkg::NUM_PATHS*pa_protect_pkg::SAMPLE_W-1:0] sample_q,
    output logic [pa_protect_pkg::NUM_PATHS-1:0] tx_gate_status_r,
    output logic [pa_protect_pkg::NUM_PATHS-1:0] tx_gate_fsm_enable_r,
    output logic [pa_protect_pkg::NUM_PATHS-1:0] flush_enable_r,
    output logic [pa_protect_pkg::NUM_PATHS-1:0] power_error_r,
    output logic [pa_protect_pkg::IRQ_W-1:0] link_event_irq_enables_r
);
    localparam int NP = pa_protect_pkg::NUM_PATHS;

    logic [NP-1:0] gate_meta_r;
    logic [NP-1:0] gate_sync_r;
    logic [NP-1:0] sw_tx_gate_override_r;
    logic [NP-1:0] sw_tx_gate_override_nxt;
    logic [NP-1:0] sw_tx_gate_value_r;
    logic [NP-1:0] sw_tx_gate_value_nxt;
    logic [NP-1:0] tx_gate_fsm_enable_nxt;
    logic [NP-1:0] flush_enable_nxt;
    logic [NP-1:0] short_window_enable_r;
    logic [NP-1:0] short_window_enable_nxt;
    logic [pa_protect_pkg::LEN_W-1:0] short_window_length_r [NP];
    logic [pa_protect_pkg::LEN_W-1:0] short_window_length_nxt [NP];
    logic [pa_protect_pkg::POWER_W-1:0] short_window_limit_r [NP];
    logic [pa_protect_pkg::POWER_W-1:0] short_window_limit_nxt [NP];
    logic [pa_protect_pkg::POWER_W-1:0] short_window_power [NP];
    logic [NP-1:0] limit_error;
    logic [NP-1:0] tx_gate_status_nxt;
    logic [NP-1:0] power_error_nxt;
    logic [pa_protect_pkg::IRQ_W-1:0] link_event_irq_enables_nxt;
    logic [pa_protect_pkg::DATA_W-1:0] reg_rdata_nxt;
    logic [$clog2(NP)-1:0] read_page;

    // averaging engine per datapath
    genvar g;
    generate
        for (g = 0; g < NP; g++) begin : g_path
            short_window_power u_power (
                .sys_clk(sys_clk),
                .reset(reset),
                .pa_tick(pa_tick[g]), // R11
                .sample_i(sample_i[g*pa_protect_pkg::SAMPLE_W +: pa_protect_pkg::SAMPLE_W]),
                .sample_q(sample_q[g*pa_protect_pkg::SAMPLE_W +: pa_protect_pkg::SAMPLE_W]),
                .short_window_enable(short_window_enable_r[g]),
                .short_window_length(short_window_length_r[g]),
                .short_window_limit(short_window_limit_r[g]),
                .short_window_power_r(short_window_power[g]),
                .limit_error_r(limit_error[g])
            );
        end
    endgenerate

    // read copy: lowest selected page
    always_comb begin
        read_page = '0;
        for (int p = NP - 1; p >= 0; p--) begin
            if (main_datapath_page_select[p]) begin
                read_page = p[$clog2(NP)-1:0]; // R03
            end
        end
    end

    // register writes, per page
    always_comb begin
        sw_tx_gate_override_nxt = sw_tx_gate_override_r;
        sw_tx_gate_value_nxt = sw_tx_gate_value_r;
        tx_gate_fsm_enable_nxt = tx_gate_fsm_enable_r;
        flush_enable_nxt = flush_enable_r;
        short_window_enable_nxt = short_window_enable_r;
        short_window_length_nxt = short_window_length_r;
        short_window_limit_nxt = short_window_limit_r;
        link_event_irq_enables_nxt = link_event_irq_enables_r;
        if (reg_write) begin
            for (int p = 0; p < NP; p++) begin
                if (main_datapath_page_select[p]) begin // R03
                    unique case (reg_addr)
                        pa_protect_pkg::ADDR_LIMIT_LOW: begin
                            short_window_limit_nxt[p][7:0] = reg_wdata; // R13
                        end
                        pa_protect_pkg::ADDR_LIMIT_HIGH: begin
                            short_window_limit_nxt[p][12:8] = reg_wdata[4:0]; // R13
                        end
                        pa_protect_pkg::ADDR_SHORT_CONTROL: begin
                            short_window_enable_nxt[p] = reg_wdata[pa_protect_pkg::BIT_SHORT_ENABLE]; // R12
                            short_window_length_nxt[p] = reg_wdata[pa_protect_pkg::LEN_W-1:0]; // R10
                        end
                        pa_protect_pkg::ADDR_FSM_CONTROL: begin
                            tx_gate_fsm_enable_nxt[p] = reg_wdata[pa_protect_pkg::BIT_FSM_ENABLE]; // R04
                        end
                        pa_protect_pkg::ADDR_BLANKING: begin
                            sw_tx_gate_override_nxt[p] = reg_wdata[pa_protect_pkg::BIT_SW_OVERRIDE]; // R05
                            sw_tx_gate_value_nxt[p] = reg_wdata[pa_protect_pkg::BIT_SW_VALUE]; // R06
                        end
                        pa_protect_pkg::ADDR_FLUSH: begin
                            flush_enable_nxt[p] = reg_wdata[pa_protect_pkg::BIT_FLUSH_ENABLE]; // R09
                        end
                        default: begin
                        end
                    endcase
                end
            end
            // link interrupt enables are not paged
            if (reg_addr == pa_protect_pkg::ADDR_IRQ_LOW) begin
                link_event_irq_enables_nxt[7:0] = reg_wdata; // R07 R08
            end
            if (reg_addr == pa_protect_pkg::ADDR_IRQ_HIGH) begin
                link_event_irq_enables_nxt[pa_protect_pkg::BIT_IRQ_HIGH] = reg_wdata[0]; // R08
            end
        end
    end

    // gate status, error and readback
    always_comb begin
        for (int p = 0; p < NP; p++) begin
            tx_gate_status_nxt[p] = sw_tx_gate_override_r[p] ? sw_tx_gate_value_r[p] : gate_sync_r[p]; // R05 R06
        end
        power_error_nxt = limit_error & short_window_enable_r; // R12 R13
        reg_rdata_nxt = pa_protect_pkg::READ_ZERO;
        unique case (reg_addr)
            pa_protect_pkg::ADDR_LIMIT_LOW: begin
                reg_rdata_nxt = short_window_limit_r[read_page][7:0];
            end
            pa_protect_pkg::ADDR_LIMIT_HIGH: begin
                reg_rdata_nxt = {3'h0, short_window_limit_r[read_page][12:8]};
            end
            pa_protect_pkg::ADDR_SHORT_CONTROL: begin
                reg_rdata_nxt = {short_window_enable_r[read_page], 5'h00, short_window_length_r[read_page]};
            end
            pa_protect_pkg::ADDR_POWER_LOW: begin
                reg_rdata_nxt = short_window_power[read_page][7:0]; // R02 R14
            end
            pa_protect_pkg::ADDR_POWER_HIGH: begin
                reg_rdata_nxt = {3'h0, short_window_power[read_page][12:8]}; // R02 R14
            end
            pa_protect_pkg::ADDR_FSM_CONTROL: begin
                reg_rdata_nxt = {7'h00, tx_gate_fsm_enable_r[read_page]};
            end
            pa_protect_pkg::ADDR_BLANKING: begin
                reg_rdata_nxt = {4'h0, sw_tx_gate_value_r[read_page], sw_tx_gate_override_r[read_page], 2'h0};
            end
            pa_protect_pkg::ADDR_IRQ_LOW: begin
                reg_rdata_nxt = link_event_irq_enables_r[7:0];
            end
            pa_protect_pkg::ADDR_IRQ_HIGH: begin
                reg_rdata_nxt = {7'h00, link_event_irq_enables_r[pa_protect_pkg::BIT_IRQ_HIGH]}; // R08
            end
            pa_protect_pkg::ADDR_FLUSH: begin
                reg_rdata_nxt = {7'h00, flush_enable_r[read_page]};
            end
            default: begin
                reg_rdata_nxt = pa_protect_pkg::READ_ZERO;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            gate_meta_r <= '0;
            gate_sync_r <= '0;
            sw_tx_gate_override_r <= {NP{pa_protect_pkg::SW_OVERRIDE_RESET}}; // R05
            sw_tx_gate_value_r <= {NP{pa_protect_pkg::SW_VALUE_RESET}};
            tx_gate_fsm_enable_r <= {NP{pa_protect_pkg::FSM_ENABLE_RESET}}; // R04
            flush_enable_r <= {NP{pa_protect_pkg::FLUSH_ENABLE_RESET}}; // R09
            short_window_enable_r <= {NP{pa_protect_pkg::SHORT_ENABLE_RESET}};
            for (int p = 0; p < NP; p++) begin
                short_window_length_r[p] <= pa_protect_pkg::LENGTH_RESET;
                short_window_limit_r[p] <= pa_protect_pkg::LIMIT_RESET;
            end
            link_event_irq_enables_r <= pa_protect_pkg::IRQ_RESET;
            tx_gate_status_r <= '0;
            power_error_r <= '0;
            reg_rdata_r <= pa_protect_pkg::READ_ZERO;
        end else begin
            gate_meta_r <= tx_gate_input;
            gate_sync_r <= gate_meta_r;
            sw_tx_gate_override_r <= sw_tx_gate_override_nxt;
            sw_tx_gate_value_r <= sw_tx_gate_value_nxt;
            tx_gate_fsm_enable_r <= tx_gate_fsm_enable_nxt;
            flush_enable_r <= flush_enable_nxt;
            short_window_enable_r <= short_window_enable_nxt;
            short_window_length_r <= short_window_length_nxt;
            short_window_limit_r <= short_window_limit_nxt;
            link_event_irq_enables_r <= link_event_irq_enables_nxt;
            tx_gate_status_r <= tx_gate_status_nxt;
            power_error_r <= power_error_nxt;
            reg_rdata_r <= reg_rdata_nxt;
        end
    end
endmodule : pa_protect_txen_regs

// ===== bench/pa_protect_txen_regs_sva.sv
// assertion checker for the protection register bank
`timescale 1ns/1ps
module pa_protect_txen_regs_sva (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [pa_protect_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_write,
    input wire logic [pa_protect_pkg::DATA_W-1:0] reg_wdata,
    input wire logic [pa_protect_pkg::DATA_W-1:0] reg_rdata_r,
    input wire logic [pa_protect_pkg::NUM_PATHS-1:0] main_datapath_page_select,
    input wire logic [pa_protect_pkg::NUM_PATHS-1:0] tx_gate_status_r,
    input wire logic [pa_protect_pkg::NUM_PATHS-1:0] tx_gate_fsm_enable_r,
    input wire logic [pa_protect_pkg::NUM_PATHS-1:0] flush_enable_r,
    input wire logic [pa_protect_pkg::IRQ_W-1:0] link_event_irq_enables_r
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    fsm_enable_write_a: assert property (reg_write && reg_addr == pa_protect_pkg::ADDR_FSM_CONTROL
        && main_datapath_page_select[0] |=> tx_gate_fsm_enable_r[0] == $past(reg_wdata[0]))
        else $error("fsm enable not written");
    page_isolation_a: assert property (reg_write && !main_datapath_page_select[0] |=>
        $stable(tx_gate_fsm_enable_r[0]) && $stable(flush_enable_r[0])) else $error("unselected copy changed");
    sw_gate_value_a: assert property (reg_write && reg_addr == pa_protect_pkg::ADDR_BLANKING
        && main_datapath_page_select[0] && reg_wdata[2] ##1 !(reg_write && reg_addr == pa_protect_pkg::ADDR_BLANKING)
        |=> tx_gate_status_r[0] == $past(reg_wdata[3], 2)) else $error("software gate value not applied");
    flush_write_a: assert property (reg_write && reg_addr == pa_protect_pkg::ADDR_FLUSH
        && main_datapath_page_select[0] |=> flush_enable_r[0] == $past(reg_wdata[0])) else $error("flush not written");
    irq_low_write_a: assert property (reg_write && reg_addr == pa_protect_pkg::ADDR_IRQ_LOW |=>
        link_event_irq_enables_r[7:0] == $past(reg_wdata)) else $error("irq low byte not written");
    irq_high_write_a: assert property (reg_write && reg_addr == pa_protect_pkg::ADDR_IRQ_HIGH |=>
        link_event_irq_enables_r[8] == $past(reg_wdata[0])) else $error("irq bit 8 not written");
    irq_hold_a: assert property (!(reg_write && (reg_addr == pa_protect_pkg::ADDR_IRQ_LOW
        || reg_addr == pa_protect_pkg::ADDR_IRQ_HIGH)) |=> $stable(link_event_irq_enables_r))
        else $error("irq enables changed without write");
    reset_values_a: assert property ($fell(reset) |-> flush_enable_r == 2'h3
        && tx_gate_fsm_enable_r == 2'h0 && link_event_irq_enables_r == 9'h000) else $error("bad reset values");
    reserved_bits_a: assert property (reg_addr == pa_protect_pkg::ADDR_POWER_HIGH |=> reg_rdata_r[7:5] == 3'h0)
        else $error("power high reserved bits set");
    irq_reserved_a: assert property (reg_addr == pa_protect_pkg::ADDR_IRQ_HIGH |=> reg_rdata_r[7:1] == 7'h00)
        else $error("irq high reserved bits set");
endmodule : pa_protect_txen_regs_sva
bind pa_protect_txen_regs pa_protect_txen_regs_sva pa_protect_txen_regs_sva_i (.sys_clk(sys_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
    .main_datapath_page_select(main_datapath_page_select), .tx_gate_status_r(tx_gate_status_r),
    .tx_gate_fsm_enable_r(tx_gate_fsm_enable_r), .flush_enable_r(flush_enable_r),
    .link_event_irq_enables_r(link_event_irq_enables_r));

// ===== bench/pa_protect_txen_regs_bench.sv
// self-checking bench for the protection register bank
`timescale 1ns/1ps
module pa_protect_txen_regs_bench;
    logic sys_clk = 1'b0;
    logic reset;
    logic [11:0] reg_addr;
    logic reg_write;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata_r;
    logic [1:0] page;
    logic [1:0] tx_gate_input;
    logic [1:0] pa_tick;
    logic [31:0] sample_i;
    logic [31:0] sample_q;
    logic [1:0] tx_gate_status_r;
    logic [1:0] tx_gate_fsm_enable_r;
    logic [1:0] flush_enable_r;
    logic [1:0] power_error_r;
    logic [8:0] link_event_irq_enables_r;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    always #5 sys_clk = ~sys_clk;
    pa_protect_txen_regs pa_protect_txen_regs_i (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .main_datapath_page_select(page),
        .tx_gate_input(tx_gate_input), .pa_tick(pa_tick), .sample_i(sample_i), .sample_q(sample_q),
        .tx_gate_status_r(tx_gate_status_r), .tx_gate_fsm_enable_r(tx_gate_fsm_enable_r),
        .flush_enable_r(flush_enable_r), .power_error_r(power_error_r),
        .link_event_irq_enables_r(link_event_irq_enables_r));
    task automatic test_done();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            $display("[ERR] %0t run timed out", $time);
            test_done();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        @(posedge sys_clk);
        #1;
        chk(reg_rdata_r, exp);
    endtask : rd
    task automatic setpg(input logic [1:0] p);
        @(posedge sys_clk);
        page <= p;
    endtask : setpg
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wait_cyc
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            pa_tick <= 2'b01;
            @(posedge sys_clk);
            pa_tick <= 2'b00;
        end
    endtask : tick
    task automatic t_reset_values();
        logic [11:0] addrs [11] = '{12'h588, 12'h589, 12'h58A, 12'h58B, 12'h58C, 12'h58D, 12'h596, 12'h597,
            12'h598, 12'h599, 12'h700};
        logic [7:0] vals [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
        chk(flush_enable_r, 16'h0003);
        for (int k = 0; k < 11; k++) begin
            rd(addrs[k], vals[k]);
        end
        wr(12'h58B, 8'hFF);
        rd(12'h58B, 8'h00);
    endtask : t_reset_values
    task automatic t_fsm_page();
        wr(12'h58D, 8'hFF);
        chk(tx_gate_fsm_enable_r, 16'h0001);
        rd(12'h58D, 8'h01);
        setpg(2'b10);
        rd(12'h58D, 8'h00);
        wr(12'h58D, 8'h01);
        chk(tx_gate_fsm_enable_r, 16'h0003);
        setpg(2'b11);
        wr(12'h58D, 8'h00);
        chk(tx_gate_fsm_enable_r, 16'h0000);
    endtask : t_fsm_page
    task automatic t_override();
        setpg(2'b01);
        tx_gate_input <= 2'b11;
        wait_cyc(4);
        chk(tx_gate_status_r, 16'h0003);
        wr(12'h596, 8'h04);
        wait_cyc(1);
        chk(tx_gate_status_r, 16'h0002);
        wr(12'h596, 8'h0C);
        tx_gate_input <= 2'b00;
        wait_cyc(4);
        chk(tx_gate_status_r, 16'h0001);
        rd(12'h596, 8'h0C);
        wr(12'h596, 8'h00);
        wait_cyc(1);
        chk(tx_gate_status_r, 16'h0000);
    endtask : t_override
    task automatic t_irq_flush();
        wr(12'h597, 8'hA5);
        wr(12'h598, 8'hFF);
        chk(link_event_irq_enables_r, 16'h01A5);
        rd(12'h598, 8'h01);
        wr(12'h598, 8'h00);
        chk(link_event_irq_enables_r, 16'h00A5);
        setpg(2'b10);
        wr(12'h599, 8'h00);
        chk(flush_enable_r, 16'h0001);
        rd(12'h599, 8'h00);
    endtask : t_irq_flush
    task automatic t_power();
        setpg(2'b01);
        sample_i <= 32'h0000_8000;
        sample_q <= 32'h0000_8000;
        wr(12'h588, 8'h00);
        wr(12'h589, 8'h08);
        wr(12'h58A, 8'h81);
        tick(2);
        wait_cyc(2);
        chk(power_error_r, 16'h0000);
        rd(12'h58B, 8'h00);
        rd(12'h58C, 8'h08);
        wr(12'h588, 8'hFF);
        wr(12'h589, 8'h07);
        rd(12'h588, 8'hFF);
        rd(12'h589, 8'h07);
        tick(2);
        wait_cyc(2);
        chk(power_error_r, 16'h0001);
        wr(12'h58A, 8'h01);
        wait_cyc(2);
        chk(power_error_r, 16'h0000);
        sample_i <= 32'h0000_0C00;
        sample_q <= 32'h0000_F800;
        tick(2);
        rd(12'h58C, 8'h08);
        wr(12'h58A, 8'h80);
        tick(1);
        wait_cyc(2);
        rd(12'h58B, 8'h0D);
        rd(12'h58C, 8'h00);
        // second datapath averages on its own tick
        setpg(2'b10);
        sample_i <= 32'h8000_0C00;
        sample_q <= 32'h0000_F800;
        wr(12'h58A, 8'h80);
        rd(12'h58A, 8'h80);
        @(posedge sys_clk);
        pa_tick <= 2'b10;
        @(posedge sys_clk);
        pa_tick <= 2'b00;
        wait_cyc(2);
        chk(power_error_r, 16'h0002);
        rd(12'h58B, 8'h00);
        rd(12'h58C, 8'h04);
        setpg(2'b01);
        rd(12'h58B, 8'h0D);
    endtask : t_power
    initial begin
        reset = 1'b1;
        reg_addr = 12'h000;
        reg_write = 1'b0;
        reg_wdata = 8'h00;
        page = 2'b01;
        tx_gate_input = 2'b00;
        pa_tick = 2'b00;
        sample_i = 32'h0000_0000;
        sample_q = 32'h0000_0000;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        wait_cyc(1);
        t_reset_values();
        t_fsm_page();
        t_override();
        t_irq_flush();
        t_power();
        test_done();
    end
endmodule : pa_protect_txen_regs_bench
